// File: hw/svlmon_pkg.sv
// Constants, register map and types shared by the supply droop monitor.
package svlmon_pkg;
   // ****************************************
   // Clock and timing.
   // ****************************************
   // System clock period in nanoseconds.
   localparam int CLK_PERIOD_NS = 8;
   // Qualifying delay from detect flag rising to the interrupt request, in ns.
   localparam int QUALIFY_DELAY_NS = 15000;
   // Qualifying delay as a count of clock cycles, rounded up.
   localparam int QUALIFY_CYCLES = (QUALIFY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Width of the qualifying delay counter.
   localparam int QUAL_CNT_W = 12;
   // Terminal count of the qualifying delay counter.
   localparam logic [QUAL_CNT_W-1:0] QUAL_LAST = QUAL_CNT_W'(QUALIFY_CYCLES - 1);
   // Counter start value.
   localparam logic [QUAL_CNT_W-1:0] QUAL_ZERO = 12'h000;

   // ****************************************
   // Register byte offsets.
   // ****************************************
   localparam logic [11:0] OFS_CONTROL = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_IRQ_FLAG = 12'h008;
   localparam logic [11:0] OFS_MASK = 12'h00c;

   // ****************************************
   // Control register layout.
   // ****************************************
   // Trip level select field, bits 2 to 0.
   localparam int CTL_LVL_LSB = 0;
   localparam int CTL_LVL_MSB = 2;
   // Detector enable, read and write.
   localparam int CTL_EN_BIT = 4;
   // Read only undervoltage flag.
   localparam int CTL_FLAG_BIT = 5;
   // Control register reset value.
   localparam logic [7:0] CTL_RESET = 8'h00;

   // ****************************************
   // Status, mask and flag layout.
   // ****************************************
   // Number of sticky event bits.
   localparam int EVT_W = 3;
   // Event: qualifying delay expired, request flag set.
   localparam int EVT_QUAL = 0;
   // Event: detect flag rose.
   localparam int EVT_RISE = 1;
   // Event: detect flag fell.
   localparam int EVT_FALL = 2;
   // Reset value of status and mask.
   localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;
   // Bit of the request flag in its own register.
   localparam int IRQF_BIT = 0;

   // ****************************************
   // Trip level codes, lowest to highest.
   // ****************************************
   localparam logic [2:0] LVL_2V0 = 3'h0;
   localparam logic [2:0] LVL_4V0 = 3'h7;

   // Qualifying delay sequencer states.
   typedef enum logic [1:0] {
      QUAL_IDLE = 2'b00,
      QUAL_COUNT = 2'b01,
      QUAL_DONE = 2'b10
   } svlmon_qual_state_type;
endpackage : svlmon_pkg

// File: hw/svlmon_sync.sv
// Two flip-flop level synchroniser with an asynchronous active low reset.
`timescale 1ns/1ps
`default_nettype none
module svlmon_sync (
   // Clock and reset.
   input wire logic clk,
   input wire logic rstN,
   // Asynchronous level in, synchronised level out.
   input wire logic dIn,
   output logic qOut
);
   // First stage, read only by the second stage.
   logic meta_reg;

   // ****************************************
   // Two stage capture.
   // ****************************************
   // Both stages reset to zero, so a released reset propagates cleanly.
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         meta_reg <= 1'b0;
         qOut <= 1'b0;
      end else begin
         meta_reg <= dIn;
         qOut <= meta_reg;
      end
   end
endmodule // svlmon_sync
`default_nettype wire

// File: hw/svlmon_top.sv
// Supply droop detector control, status and interrupt logic with an APB slave.
`timescale 1ns/1ps
`default_nettype none
module svlmon_top
   import svlmon_pkg::*;
(
   // Clock and asynchronous reset.
   input wire logic ref_clk,
   input wire logic arst_n,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog comparator and reference.
   input wire logic compBelow,
   output logic compEnable,
   output logic [2:0] tripLevel,
   // Power mode and system requests.
   input wire logic lowPowerMode,
   output logic wakeReq,
   output logic irq
);
   // ****************************************
   // Declarations.
   // ****************************************
   // Synchronised reset, active low.
   logic rstSyncN;
   // Synchronised comparator output.
   logic compSync;
   // Control register fields.
   logic [2:0] level_reg;
   logic enable_reg;
   // Detect flag and its previous value.
   logic flag_reg;
   logic flagPrev_reg;
   // Request flag and its next value.
   logic irqFlag_reg;
   logic irqFlag_next;
   // Sticky event bits, mask and next status.
   logic [EVT_W-1:0] status_reg;
   logic [EVT_W-1:0] status_next;
   logic [EVT_W-1:0] mask_reg;
   logic [EVT_W-1:0] evtSet;
   // Qualifying delay sequencer.
   svlmon_qual_state_type qual_reg;
   logic [QUAL_CNT_W-1:0] qualCnt_reg;
   // One cycle pulse when the delay expires.
   logic hwSet;
   // Bus strobes.
   logic setupRd;
   logic setupPh;
   logic wrAcc;
   logic wrCtl;
   logic wrSts;
   logic wrIrqf;
   logic wrMsk;
   // Read data output register and error register.
   logic [31:0] rdata_reg;
   logic err_reg;
   // Wake request register.
   logic wake_reg;

   // Returns one when the byte address is a mapped register.
   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == OFS_CONTROL) || (a == OFS_STATUS) ||
                  (a == OFS_IRQ_FLAG) || (a == OFS_MASK);
   endfunction

   // ****************************************
   // Synchronisers.
   // ****************************************
   // Reset release passes two flops; assertion stays asynchronous.
   svlmon_sync u_rst_sync (
      .clk(ref_clk),
      .rstN(arst_n),
      .dIn(1'b1),
      .qOut(rstSyncN)
   );

   // The comparator is analog and free running, so it is synchronised first.
   svlmon_sync u_comp_sync (
      .clk(ref_clk),
      .rstN(rstSyncN),
      .dIn(compBelow),
      .qOut(compSync)
   );

   // ****************************************
   // APB decode.
   // ****************************************
   // Setup phase starts a transfer; writes land at the access edge.
   assign setupPh = psel && !penable;
   assign setupRd = setupPh && !pwrite;
   assign wrAcc = psel && penable && pwrite;
   // Address decoding for writes.
   always_comb begin
      wrCtl = 1'b0;
      wrSts = 1'b0;
      wrIrqf = 1'b0;
      wrMsk = 1'b0;
      if (wrAcc && (paddr == OFS_CONTROL)) begin
         wrCtl = 1'b1;
      end else if (wrAcc && (paddr == OFS_STATUS)) begin
         wrSts = 1'b1;
      end else if (wrAcc && (paddr == OFS_IRQ_FLAG)) begin
         wrIrqf = 1'b1;
      end else if (wrAcc && (paddr == OFS_MASK)) begin
         wrMsk = 1'b1;
      end
   end

   // Read data is captured in the setup cycle so the access cycle answers at once.
   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         rdata_reg <= 32'h0000_0000;
      end else if (setupRd) begin
         rdata_reg <= 32'h0000_0000;
         if (paddr == OFS_CONTROL) begin
            // Unused bits above and at seven, six and three stay zero.
            rdata_reg[CTL_LVL_MSB:CTL_LVL_LSB] <= level_reg;
            rdata_reg[CTL_EN_BIT] <= enable_reg;
            rdata_reg[CTL_FLAG_BIT] <= flag_reg;
         end else if (paddr == OFS_STATUS) begin
            rdata_reg[EVT_W-1:0] <= status_reg;
         end else if (paddr == OFS_IRQ_FLAG) begin
            rdata_reg[IRQF_BIT] <= irqFlag_reg;
         end else if (paddr == OFS_MASK) begin
            rdata_reg[EVT_W-1:0] <= mask_reg;
         end
      end
   end

   // Unmapped addresses answer with an error; writes to them change nothing.
   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         err_reg <= 1'b0;
      end else if (setupPh) begin
         err_reg <= !is_mapped(paddr);
      end
   end

   // The slave never inserts wait states.
   assign pready = 1'b1;
   assign prdata = rdata_reg;
   assign pslverr = err_reg && psel && penable;

   // ****************************************
   // Control register.
   // ****************************************
   // Level and enable are plain storage; the detect flag cannot be written.
   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         level_reg <= CTL_RESET[CTL_LVL_MSB:CTL_LVL_LSB];
         enable_reg <= CTL_RESET[CTL_EN_BIT];
      end else if (wrCtl) begin
         level_reg <= pwdata[CTL_LVL_MSB:CTL_LVL_LSB];
         enable_reg <= pwdata[CTL_EN_BIT];
      end
   end

   // Low power mode does not touch the enable, so the comparator keeps running.
   assign compEnable = enable_reg;
   // Code zero is the lowest level and code seven the highest.
   assign tripLevel = level_reg;

   // ****************************************
   // Detect flag.
   // ****************************************
   // Disabled circuits read as no low voltage condition.
   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         flag_reg <= 1'b0;
         flagPrev_reg <= 1'b0;
      end else begin
         flag_reg <= compSync && enable_reg;
         flagPrev_reg <= flag_reg;
      end
   end

   // ****************************************
   // Qualifying delay.
   // ****************************************
   // The count restarts whenever the flag drops, so chatter near the level
   // does not accumulate into a request.
   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         qual_reg <= QUAL_IDLE;
         qualCnt_reg <= QUAL_ZERO;
      end else begin
         case (qual_reg)
            QUAL_IDLE: begin
               qualCnt_reg <= QUAL_ZERO;
               if (flag_reg) begin
                  qual_reg <= QUAL_COUNT;
               end
            end
            QUAL_COUNT: begin
               if (!flag_reg) begin
                  qual_reg <= QUAL_IDLE;
                  qualCnt_reg <= QUAL_ZERO;
               end else if (qualCnt_reg == QUAL_LAST) begin
                  qual_reg <= QUAL_DONE;
               end else begin
                  qualCnt_reg <= qualCnt_reg + 1'b1;
               end
            end
            QUAL_DONE: begin
               // One request per low voltage episode.
               qualCnt_reg <= QUAL_ZERO;
               if (!flag_reg) begin
                  qual_reg <= QUAL_IDLE;
               end
            end
            default: begin
               qual_reg <= QUAL_IDLE;
               qualCnt_reg <= QUAL_ZERO;
            end
         endcase
      end
   end

   // Expiry pulse, only while the flag still stands.
   assign hwSet = (qual_reg == QUAL_COUNT) && flag_reg && (qualCnt_reg == QUAL_LAST);

   // ****************************************
   // Request flag.
   // ****************************************
   // Software writes any value; a hardware set in the same cycle wins.
   always_comb begin
      irqFlag_next = irqFlag_reg;
      if (wrIrqf) begin
         irqFlag_next = pwdata[IRQF_BIT];
      end
      if (hwSet) begin
         irqFlag_next = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         irqFlag_reg <= 1'b0;
      end else begin
         irqFlag_reg <= irqFlag_next;
      end
   end

   // A wake pulse only when hardware raises a flag that was low, so a flag
   // preset by software before sleep suppresses the wake.
   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         wake_reg <= 1'b0;
      end else begin
         wake_reg <= hwSet && !irqFlag_reg && lowPowerMode;
      end
   end
   assign wakeReq = wake_reg;

   // ****************************************
   // Shared interrupt status and mask.
   // ****************************************
   // Event sources merged into the one shared line.
   assign evtSet[EVT_QUAL] = hwSet && !irqFlag_reg;
   assign evtSet[EVT_RISE] = flag_reg && !flagPrev_reg;
   assign evtSet[EVT_FALL] = !flag_reg && flagPrev_reg;

   // Write one to clear; a set in the same cycle wins over the clear.
   always_comb begin
      status_next = status_reg;
      if (wrSts) begin
         status_next = status_reg & ~pwdata[EVT_W-1:0];
      end
      status_next = status_next | evtSet;
   end

   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         status_reg <= EVT_RESET;
      end else begin
         status_reg <= status_next;
      end
   end

   // Mask bits enable each status bit onto the line.
   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         mask_reg <= EVT_RESET;
      end else if (wrMsk) begin
         mask_reg <= pwdata[EVT_W-1:0];
      end
   end

   // No dedicated vector: the request only reaches the core here.
   assign irq = |(status_reg & mask_reg);

   // ****************************************
   // Assertions.
   // ****************************************
   // Rise of the detect flag from low to high.
   sequence s_flag_rise;
      !flag_reg ##1 flag_reg;
   endsequence

   a_trip_level: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
      wrCtl |=> tripLevel == $past(pwdata[CTL_LVL_MSB:CTL_LVL_LSB]))
      else $error("trip level does not follow control write");

   a_flag_follows: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
      (enable_reg && compBelow)[*4] |-> flag_reg)
      else $error("detect flag low while supply below level");

   a_comp_synced: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
      $rose(compBelow) && !flag_reg |=> !flag_reg)
      else $error("comparator reached flag without two stages");

   a_flag_readback: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
      setupRd && paddr == OFS_CONTROL |=> prdata[CTL_FLAG_BIT] == $past(flag_reg))
      else $error("control read shows wrong detect flag");

   a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
      setupRd && paddr == OFS_CONTROL |=> prdata[7:6] == 2'h0 && !prdata[3])
      else $error("reserved control bits read nonzero");

   a_enable_write: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
      wrCtl |=> compEnable == $past(pwdata[CTL_EN_BIT]))
      else $error("detector enable does not follow write");

   a_sleep_keeps: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
      compEnable && lowPowerMode && !wrCtl |=> compEnable)
      else $error("detector dropped in low power mode");

   a_qual_delay: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
      s_flag_rise |-> !hwSet [*8])
      else $error("request raised before qualifying delay");

   a_qual_expiry: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
      hwSet |-> qualCnt_reg == QUAL_LAST && flag_reg)
      else $error("expiry without full delay count");

   a_irq_set: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
      hwSet |=> irqFlag_reg)
      else $error("request flag not set on expiry");

   a_irq_hold: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
      irqFlag_reg && !wrIrqf |=> irqFlag_reg)
      else $error("request flag cleared without a write");

   a_wake_pulse: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
      hwSet && !irqFlag_reg && lowPowerMode |=> wakeReq ##1 !wakeReq)
      else $error("wake not pulsed on request set");

   a_merged_irq: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
      hwSet && !irqFlag_reg && mask_reg[EVT_QUAL] && !wrMsk |=> irq)
      else $error("shared interrupt not raised by request");
endmodule // svlmon_top
`default_nettype wire

// File: tb/svlmon_comp_model.sv
// Behavioural model of the analog supply comparator and its reference.
`timescale 1ns/1ps
`default_nettype none
module svlmon_comp_model (
   // Clock.
   input wire logic ref_clk,
   // Control from the monitor.
   input wire logic compEnable,
   input wire logic [2:0] tripLevel,
   // Supply voltage in millivolts, set by the bench.
   input wire logic [12:0] supplyMv,
   // Comparator output, high while the supply is below the level.
   output logic compBelow
);
   // ****************************************
   // Reference levels.
   // ****************************************
   // Trip levels in millivolts, ascending from code 0 to code 7.
   localparam logic [12:0] TRIP_MV [8] = '{13'h07d0, 13'h0898, 13'h0960, 13'h0a8c,
      13'h0bb8, 13'h0ce4, 13'h0e10, 13'h0fa0};

   // Powered-down comparator output wanders, so the monitor must gate it.
   logic idleToggle = 1'b0;

   // ****************************************
   // Comparator.
   // ****************************************
   // The unpowered output changes every cycle rather than holding a value.
   always @(posedge ref_clk) begin
      idleToggle <= ~idleToggle;
   end

   // The comparator keeps working whatever the core's power mode is.
   assign compBelow = compEnable ? (supplyMv < TRIP_MV[tripLevel]) : idleToggle;
endmodule // svlmon_comp_model
`default_nettype wire

// File: tb/supply_low_voltage_monitor_tb.sv
// Self-checking testbench for the supply droop monitor.
`timescale 1ns/1ps
`default_nettype none
module supply_low_voltage_monitor_tb import svlmon_pkg::*; ;
   // ****************************************
   // Signals.
   // ****************************************
   // Trip levels in millivolts, used to place the supply around each level.
   localparam logic [12:0] TRIP_MV [8] = '{13'h07d0, 13'h0898, 13'h0960, 13'h0a8c,
      13'h0bb8, 13'h0ce4, 13'h0e10, 13'h0fa0};
   logic refClk = 1'b0;
   logic arstN = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic compBelow;
   logic compEnable;
   logic [2:0] tripLevel;
   logic lowPowerMode = 1'b0;
   logic wakeReq;
   logic irq;
   logic [12:0] supplyMv = 13'h1194;
   int numErrors = 0;
   int comparisons = 0;
   int wakeCount = 0;

   // Clock of 8 ns period.
   always #4 refClk = ~refClk;

   // Design and comparator model.
   svlmon_top DUT (.ref_clk(refClk), .arst_n(arstN), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .compBelow(compBelow), .compEnable(compEnable),
      .tripLevel(tripLevel), .lowPowerMode(lowPowerMode), .wakeReq(wakeReq), .irq(irq));
   svlmon_comp_model comp (.ref_clk(refClk), .compEnable(compEnable),
      .tripLevel(tripLevel), .supplyMv(supplyMv), .compBelow(compBelow));

   // Counts wake pulses so that each one is seen in the cycle it stands.
   always @(posedge refClk) begin
      if (wakeReq === 1'b1) begin
         wakeCount <= wakeCount + 1;
      end
   end

   // ****************************************
   // Tasks.
   // ****************************************
   // Compares a seen value with the expected one and counts both.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         numErrors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic endOfTest();
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, numErrors);
      if (numErrors == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // One APB transfer: setup, then access held until pready is sampled high.
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
      output logic [31:0] rdata, output logic err);
      int n;
      @(posedge refClk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
      @(posedge refClk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge refClk);
         if (pready === 1'b1) break;
      end
      // A slave that never answers ends the run.
      if (n == 16) begin
         numErrors++;
         $display("wrong value at %0t: bus hang", $time);
         endOfTest();
      end
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Register write.
   task automatic wr(input logic [11:0] addr, input logic [31:0] data);
      logic [31:0] d;
      logic e;
      apb(1'b1, addr, data, d, e);
   endtask

   // Register read.
   task automatic rd(input logic [11:0] addr, output logic [31:0] data);
      logic e;
      apb(1'b0, addr, 32'h0, data, e);
   endtask

   // ****************************************
   // Main sequence.
   // ****************************************
   initial begin
      int code;
      int n;
      int wakeBase;
      logic [31:0] d;
      logic e;
      repeat (20) @(posedge refClk);
      arstN <= 1'b1;
      repeat (3) @(posedge refClk);
      // All four registers come out of reset at zero.
      for (n = 0; n < 4; n++) begin
         rd(12'(n * 4), d);
         check(d, 32'h0);
      end
      check({31'h0, irq}, 32'h0);
      $display("Test reset values done");
      // Writing ones everywhere leaves reserved bits and the flag clear.
      wr(OFS_CONTROL, 32'hffffffff);
      // The unpowered comparator output wanders, so let it settle after enable.
      repeat (5) @(posedge refClk);
      rd(OFS_CONTROL, d);
      check(d, 32'h17);
      $display("Test control bits done");
      // Each level code, with the supply just below and then just above it.
      for (code = 0; code < 8; code++) begin
         wr(OFS_CONTROL, 32'h10 | code);
         supplyMv <= TRIP_MV[code] - 13'h0032;
         repeat (5) @(posedge refClk);
         rd(OFS_CONTROL, d);
         check(d, 32'h30 | code);
         check({29'h0, tripLevel}, 32'(code));
         supplyMv <= TRIP_MV[code] + 13'h0032;
         repeat (5) @(posedge refClk);
         rd(OFS_CONTROL, d);
         check(d, 32'h10 | code);
      end
      $display("Test trip levels done");
      // A disabled detector reports nothing even with the supply low.
      wr(OFS_CONTROL, 32'h07);
      supplyMv <= 13'h076c;
      repeat (5) @(posedge refClk);
      rd(OFS_CONTROL, d);
      check(d, 32'h07);
      check({31'h0, compEnable}, 32'h0);
      $display("Test disable done");
      // Qualifying delay, interrupt and wake while in low power.
      supplyMv <= 13'h1194;
      wr(OFS_CONTROL, 32'h17);
      repeat (5) @(posedge refClk);
      wr(OFS_STATUS, 32'h7);
      wr(OFS_IRQ_FLAG, 32'h0);
      rd(OFS_STATUS, d);
      check(d, 32'h0);
      wr(OFS_MASK, 32'h1);
      lowPowerMode <= 1'b1;
      wakeBase = wakeCount;
      supplyMv <= 13'h076c;
      for (n = 0; n < 2500; n++) begin
         @(posedge refClk);
         if (irq === 1'b1) break;
      end
      check(32'(n >= 1876 && n <= 1885), 32'h1);
      repeat (3) @(posedge refClk);
      check(wakeCount - wakeBase, 32'h1);
      rd(OFS_IRQ_FLAG, d);
      check(d, 32'h1);
      // Expiry event plus the rise of the detect flag.
      rd(OFS_STATUS, d);
      check(d, 32'h3);
      lowPowerMode <= 1'b0;
      $display("Test qualifying delay done");
      // The request flag holds and follows software writes.
      repeat (100) @(posedge refClk);
      rd(OFS_IRQ_FLAG, d);
      check(d, 32'h1);
      wr(OFS_IRQ_FLAG, 32'h0);
      rd(OFS_IRQ_FLAG, d);
      check(d, 32'h0);
      wr(OFS_IRQ_FLAG, 32'h1);
      rd(OFS_IRQ_FLAG, d);
      check(d, 32'h1);
      wr(OFS_STATUS, 32'h7);
      @(posedge refClk);
      check({31'h0, irq}, 32'h0);
      $display("Test request flag done");
      // A preset request flag suppresses the wake and the event.
      supplyMv <= 13'h1194;
      repeat (10) @(posedge refClk);
      wakeBase = wakeCount;
      lowPowerMode <= 1'b1;
      supplyMv <= 13'h076c;
      repeat (1900) @(posedge refClk);
      check(wakeCount - wakeBase, 32'h0);
      // Fall and rise of the detect flag are logged, the expiry event is not.
      rd(OFS_STATUS, d);
      check(d, 32'h6);
      check({31'h0, irq}, 32'h0);
      lowPowerMode <= 1'b0;
      $display("Test wake suppression done");
      // An unmapped address is refused and reads zero.
      apb(1'b1, 12'h010, 32'hffffffff, d, e);
      check({31'h0, e}, 32'h1);
      apb(1'b0, 12'h010, 32'h0, d, e);
      check(d, 32'h0);
      check({31'h0, e}, 32'h1);
      $display("Test unmapped address done");
      endOfTest();
   end
endmodule // supply_low_voltage_monitor_tb
`default_nettype wire
